// file: src/charger_pkg.sv
// Shared constants and types for the charger limit register block.
package charger_pkg;

  // ------------------------------------------------------------------
  // Clocking
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ  = 100_000_000;
  localparam int unsigned BUS_HZ  = 100_000;
  // Link-clock cycles per bus bit at the nominal rate (166 MHz link)
  localparam int unsigned LINK_HZ = 166_000_000;
  localparam int unsigned LINK_PER_BIT = LINK_HZ / BUS_HZ;

  // ------------------------------------------------------------------
  // Register map and field layout
  // ------------------------------------------------------------------
  localparam logic [7:0]  VOLT_REG_ADDR = 8'h00;
  localparam logic [7:0]  CURR_REG_ADDR = 8'h02;
  localparam logic [7:0]  REG_STRIDE    = 8'h02;
  localparam int          CURR_LSB      = 2;
  localparam int          CURR_MSB      = 10;
  localparam int          CURR_W        = 9;
  localparam int          VFB_W         = 5;
  localparam logic [8:0]  CURR_RESET    = 9'h190;
  localparam logic [8:0]  CURR_MIN      = 9'h008;
  localparam logic [8:0]  CURR_MAX      = 9'h190;
  localparam logic [4:0]  VFB_RESET     = 5'h10;
  localparam logic [14:0] CURR_STEP_MA  = 15'h0032;
  localparam logic [10:0] VFB_OFFSET_MV = 11'h5E0;
  localparam logic [10:0] VFB_STEP_MV   = 11'h002;

  // ------------------------------------------------------------------
  // Link framing
  // ------------------------------------------------------------------
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [6:0]  TARGET_ADDR_DEFAULT = 7'h35;  // Arbitrary value

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_ADDR  = 3'b001,
    LS_ACK   = 3'b010,
    LS_WRX   = 3'b011,
    LS_TX    = 3'b100,
    LS_TXACK = 3'b101
  } link_phase_t;

endpackage

// file: src/charger_link_target.sv
// Two-wire target that runs on the link clock and feeds the register side.
`timescale 1ns/100ps
module charger_link_target import charger_pkg::*; #(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
  input  wire logic        link_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        snap_req_in,
  input  wire logic [31:0] snap_data_in,
  output logic             snap_ack_out,
  output logic             wr_tog_out,
  output logic [7:0]       wr_addr_out,
  output logic [15:0]      wr_data_out
);

  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_f;
    logic        sda_f;
    link_phase_t ph;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic        rd;
    logic        first;
    logic        hi;
    logic        oe;
    logic [7:0]  ptr;
    logic [7:0]  lo;
    logic [2:0]  req_s;
    logic        ack;
    logic [31:0] snap;
    logic        wr_tog;
    logic [7:0]  wr_addr;
    logic [15:0] wr_data;
  } link_regs_t;

  link_regs_t  q;
  link_regs_t  d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [15:0] tx_word;
  logic [7:0]  tx_byte;

  // Word for the current pointer, low half of the snapshot is voltage
  function automatic logic [15:0] reg_word(input logic [7:0] p, input logic [31:0] s);
    if (p == VOLT_REG_ADDR) return s[15:0];
    if (p == CURR_REG_ADDR) return s[31:16];
    return 16'h0000;
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.rst_sync = {q.rst_sync[0], 1'b1};
    // Three-flop filter, a level moves once the 2nd and 3rd flops agree
    d.scl_s = {q.scl_s[1:0], scl_in};
    d.sda_s = {q.sda_s[1:0], sda_in};
    d.req_s = {q.req_s[1:0], snap_req_in};
    if (q.scl_s[1] == q.scl_s[2]) d.scl_f = q.scl_s[2];
    if (q.sda_s[1] == q.sda_s[2]) d.sda_f = q.sda_s[2];
    scl_rise = !q.scl_f && d.scl_f;
    scl_fall = q.scl_f && !d.scl_f;
    start_c  = q.scl_f && d.scl_f && q.sda_f && !d.sda_f;
    stop_c   = q.scl_f && d.scl_f && !q.sda_f && d.sda_f;
    tx_word  = reg_word(q.ptr, q.snap);
    tx_byte  = q.hi ? tx_word[15:8] : tx_word[7:0];
    // Snapshot handshake: data held still by the sender until we answer
    if (q.req_s[1] == q.req_s[2] && q.req_s[2] != q.ack) begin
      d.snap = snap_data_in;
      d.ack  = q.req_s[2];
    end
    if (stop_c || !q.rst_sync[1]) begin
      d.ph = LS_IDLE;
      d.oe = 1'b0;
    end else if (start_c) begin
      d.ph    = LS_ADDR;
      d.cnt   = 4'h0;
      d.first = 1'b1;
      d.hi    = 1'b0;
      d.oe    = 1'b0;
    end else begin
      case (q.ph)
        LS_ADDR, LS_WRX: begin
          if (scl_rise && q.cnt < BITS_PER_BYTE) begin
            d.shreg = {q.shreg[6:0], d.sda_f};
            d.cnt   = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
            d.oe = 1'b1;
            d.ph = LS_ACK;
            if (q.ph == LS_ADDR) begin
              d.rd = q.shreg[0];
              if (q.shreg[7:1] != TARGET_ADDR) begin
                d.oe = 1'b0;
                d.ph = LS_IDLE;
              end
            end else if (q.first) begin
              d.ptr   = q.shreg;
              d.first = 1'b0;
            end else if (!q.hi) begin
              d.lo = q.shreg;  // Low byte arrives first
              d.hi = 1'b1;
            end else begin
              // Full word: a further byte is the next register, never a check byte
              d.wr_addr = q.ptr;
              d.wr_data = {q.shreg, q.lo};  // Full unsigned 16-bit word
              d.wr_tog  = !q.wr_tog;
              d.ptr     = q.ptr + REG_STRIDE;  // Data runs on until the stop
              d.hi      = 1'b0;
            end
          end
        end
        LS_ACK: begin
          if (scl_fall) begin
            d.cnt = 4'h0;
            if (q.rd) begin
              d.shreg = tx_byte;
              d.oe    = !tx_byte[7];
              d.ph    = LS_TX;
            end else begin
              d.oe = 1'b0;
              d.ph = LS_WRX;
            end
          end
        end
        LS_TX: begin
          if (scl_rise && q.cnt < BITS_PER_BYTE) begin
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
            d.oe = 1'b0;
            d.ph = LS_TXACK;
            d.hi = !q.hi;
            if (q.hi) d.ptr = q.ptr + REG_STRIDE;
          end else if (scl_fall) begin
            d.shreg = {q.shreg[6:0], 1'b0};
            d.oe    = !q.shreg[6];
          end
        end
        LS_TXACK: begin
          if (scl_rise && d.sda_f) begin
            d.ph = LS_IDLE;  // Controller refused: release until next start
          end else if (scl_fall) begin
            d.cnt   = 4'h0;
            d.shreg = tx_byte;
            d.oe    = !tx_byte[7];
            d.ph    = LS_TX;
          end
        end
        default: begin
          d.ph = LS_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Open drain: only ever pull low, and only when enabled
  assign sda_out      = 1'b0;
  assign sda_oe_out   = q.oe;
  assign snap_ack_out = q.ack;
  assign wr_tog_out   = q.wr_tog;
  assign wr_addr_out  = q.wr_addr;
  assign wr_data_out  = q.wr_data;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_word_low_first: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    $changed(q.wr_tog) |-> (q.wr_data[7:0] == $past(q.lo)))
    else $error("committed word low byte is not the first data byte");
  chk_drive_scl_low: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    $rose(q.oe) |-> !q.scl_f)
    else $error("data line driven while clock high");

endmodule

// file: src/charger_limit_regs.sv
// Charger limit registers behind a two-wire target with a link clock domain.
// Functional notes
// - Current limit lives in a 16-bit register at 0x02, written over the link.
// - Only bits 10:2 carry the current code; other bits read zero.
// - Current code is 50 mA per step, clamped to 8h..190h.
// - Current code resets to 190h at power-up, on register reset or watchdog.
// - Regulated current is the lower of the code and the set-pin level.
// - Feedback voltage limit lives in a 16-bit register at 0x00.
// - Feedback code is five bits, voltage is 1504 mV plus 2 mV per step.
// - Feedback code resets to 10h at power-up and register reset, not watchdog.
// - Checked gauge transfer: address, command, low, high, then check byte.
// - In broadcast mode a check byte follows only when its enable is set.
// - With both check enables clear, no check byte is ever sent.
// - Voltage and current words travel low byte first on both links.
// - Multi-byte gauge transfers carry a count; charger transfers run to stop.
// - Both links run with a 100 kHz bus clock.
// - Gauge answers 0x15 with voltage and 0x14 with current.
// - Gauge voltage word covers the full unsigned range to 65534 mV.
`timescale 1ns/100ps
module charger_limit_regs import charger_pkg::*; #(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        link_clk_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        reg_reset_in,
  input  wire logic        watchdog_expired_in,
  input  wire logic [8:0]  current_set_pin_in,
  output logic [8:0]       current_code_out,
  output logic [14:0]      current_ma_out,
  output logic [4:0]       feedback_code_out,
  output logic [10:0]      feedback_mv_out,
  output logic [15:0]      voltage_limit_out,
  output logic [15:0]      current_limit_out
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  vfb;
    logic [8:0]  current_set_pin;
    logic [2:0]  wr_s;
    logic        wr_seen;
    logic [2:0]  ack_s;
    logic        snap_req;
    logic [31:0] snap;
    logic [8:0]  eff;
    logic [14:0] ma;
    logic [10:0] mv;
  } main_regs_t;

  localparam main_regs_t MAIN_RESET = '{
    vfb:     VFB_RESET,
    current_set_pin:    CURR_RESET,
    wr_s:    3'h0,
    wr_seen: 1'b0,
    ack_s:   3'h0,
    snap_req: 1'b0,
    snap:    32'h0000_0000,
    eff:     9'h000,
    ma:      15'h0000,
    mv:      11'h000
  };

  main_regs_t  q;
  main_regs_t  d;
  logic        wr_apply;
  logic        snap_free;
  logic        link_ack;
  logic        link_wr_tog;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  logic [8:0]  wr_curr_code;
  logic [4:0]  wr_vfb_code;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------

  // Out-of-range codes snap to the nearest legal limit
  function automatic logic [8:0] clamp_curr(input logic [8:0] c);
    if (c < CURR_MIN) return CURR_MIN;
    if (c > CURR_MAX) return CURR_MAX;
    return c;
  endfunction

  function automatic logic [8:0] min_code(input logic [8:0] a, input logic [8:0] b);
    return (a < b) ? a : b;
  endfunction

  // Register image: reserved bits above and below the field read zero
  function automatic logic [15:0] curr_word(input logic [8:0] c);
    return {5'h00, c, 2'h0};
  endfunction

  function automatic logic [15:0] volt_word(input logic [4:0] v);
    return {11'h000, v};
  endfunction

  // ------------------------------------------------------------------
  // Link side target
  // ------------------------------------------------------------------
  charger_link_target #(
    .TARGET_ADDR (TARGET_ADDR)
  ) u_link (
    .link_clk_in  (link_clk_in),
    .rst_n_in     (rst_n_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe_out   (sda_oe_out),
    .snap_req_in  (q.snap_req),
    .snap_data_in (q.snap),
    .snap_ack_out (link_ack),
    .wr_tog_out   (link_wr_tog),
    .wr_addr_out  (wr_addr),
    .wr_data_out  (wr_data)
  );

  // Field extraction from the word the link just delivered
  assign wr_curr_code = wr_data[CURR_MSB:CURR_LSB];
  assign wr_vfb_code  = wr_data[VFB_W-1:0];

  // ------------------------------------------------------------------
  // Crossing detection
  // ------------------------------------------------------------------

  // A write toggle counts once the 2nd and 3rd flops agree; the link holds
  // address and data for a whole byte time, far longer than this takes.
  assign wr_apply  = (q.wr_s[1] == q.wr_s[2]) && (q.wr_s[2] != q.wr_seen);
  // The snapshot may be refreshed once the link has answered the last one
  assign snap_free = (q.ack_s[1] == q.ack_s[2]) && (q.ack_s[2] == q.snap_req);

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.wr_s  = {q.wr_s[1:0], link_wr_tog};
    d.ack_s = {q.ack_s[1:0], link_ack};

    // Writes from the link land in the addressed field
    if (wr_apply) begin
      d.wr_seen = q.wr_s[2];
      if (wr_addr == CURR_REG_ADDR) begin
        d.current_set_pin = clamp_curr(wr_curr_code);
      end else if (wr_addr == VOLT_REG_ADDR) begin
        d.vfb = wr_vfb_code;
      end
    end

    // Resets win over a write arriving in the same cycle
    if (watchdog_expired_in || reg_reset_in) begin
      d.current_set_pin = CURR_RESET;
    end
    if (reg_reset_in) begin
      d.vfb = VFB_RESET;
    end

    // Republish both words to the link; the pair is held still until acked,
    // so a read may lag a write by a few clocks but never sees a torn word.
    if (snap_free) begin
      d.snap     = {curr_word(q.current_set_pin), volt_word(q.vfb)};
      d.snap_req = !q.snap_req;
    end

    // Regulated setpoints as registered data outputs
    d.eff = min_code(q.current_set_pin, current_set_pin_in);
    d.ma  = 15'(d.eff) * CURR_STEP_MA;
    d.mv  = VFB_OFFSET_MV + 11'(q.vfb) * VFB_STEP_MV;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= MAIN_RESET;  // Power-up values of both fields
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------

  // The set-pin level is assumed to be static or already on this clock
  assign current_code_out  = q.eff;
  assign current_ma_out    = q.ma;
  assign feedback_code_out = q.vfb;
  assign feedback_mv_out   = q.mv;
  assign voltage_limit_out = volt_word(q.vfb);
  assign current_limit_out = curr_word(q.current_set_pin);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence curr_write_s;
    wr_apply && (wr_addr == CURR_REG_ADDR) && !watchdog_expired_in && !reg_reset_in;
  endsequence

  sequence volt_write_s;
    wr_apply && (wr_addr == VOLT_REG_ADDR) && !reg_reset_in;
  endsequence

  sequence wdog_only_s;
    watchdog_expired_in && !reg_reset_in && !wr_apply;
  endsequence

  chk_wdog_curr_reset: assert property (
    watchdog_expired_in |=> (q.current_set_pin == CURR_RESET) && (current_limit_out == 16'h0640))
    else $error("watchdog did not restore the current code");

  chk_rreset_both: assert property (
    reg_reset_in |=> (q.vfb == VFB_RESET) && (q.current_set_pin == CURR_RESET))
    else $error("register reset did not restore both fields");

  chk_wdog_keeps_volt: assert property (
    wdog_only_s |=> $stable(q.vfb))
    else $error("watchdog disturbed the feedback code");

  chk_curr_write_lands: assert property (
    curr_write_s ##0 ((wr_curr_code >= CURR_MIN) && (wr_curr_code <= CURR_MAX))
    |=> (q.current_set_pin == $past(wr_curr_code)))
    else $error("in-range current write did not land");

  chk_curr_clamp_low: assert property (
    curr_write_s ##0 (wr_curr_code < CURR_MIN) |=> (q.current_set_pin == 9'h008))
    else $error("low current code not clamped to minimum");

  chk_curr_clamp_high: assert property (
    curr_write_s ##0 (wr_curr_code > CURR_MAX) |=> (q.current_set_pin == 9'h190))
    else $error("high current code not clamped to maximum");

  chk_volt_write_lands: assert property (
    volt_write_s |=> (q.vfb == $past(wr_vfb_code)) ##1 (feedback_mv_out == VFB_OFFSET_MV
    + 11'(2) * 11'($past(wr_vfb_code, 2))))
    else $error("feedback write or its millivolt image is wrong");

  chk_curr_reserved: assert property (
    (current_limit_out[15:11] == 5'h00) && (current_limit_out[1:0] == 2'h0)
    && (voltage_limit_out[15:5] == 11'h000))
    else $error("reserved bits read non-zero");

  chk_eff_is_min: assert property (
    1'b1 |=> (current_code_out <= $past(q.current_set_pin))
    && (current_code_out <= $past(current_set_pin_in))
    && ((current_code_out == $past(q.current_set_pin)) || (current_code_out == $past(current_set_pin_in))))
    else $error("regulated current is not the lower limit");

  chk_ma_scaling: assert property (
    current_ma_out == 15'(current_code_out) * CURR_STEP_MA)
    else $error("current milliamp scaling wrong");

  chk_write_crosses: assert property (
    $changed(link_wr_tog) |-> ##[2:6] wr_apply)
    else $error("link write not taken within six clocks");

endmodule

// file: verif/charge_bus_master_model.sv
// Two-wire bus controller model that writes the charger limit registers.
`timescale 1ns/100ps
module charge_bus_master_model (
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  // Quarter bit time in ns; 2500 gives the nominal 100 kHz bus clock
  int qtr = 2500;

  // ------------------------------------------------------------------
  // Idle bus: clock high and data released to the pull-up
  // ------------------------------------------------------------------
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // Data only moves while the clock is low, so no false start or stop
  task automatic put_bit(input logic b, output logic seen);
    #qtr;
    sda_low_out = !b;
    #qtr;
    scl_out = 1'b1;
    #qtr;
    seen = sda_in;
    #qtr;
    scl_out = 1'b0;
  endtask

  // Eight data bits, then a released ninth bit that the target may pull low
  task automatic put_byte(input logic [7:0] b, inout int acks);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, s);
    if (!s) acks++;
  endtask

  // ------------------------------------------------------------------
  // Register write frame, words low byte first, ended by a stop
  // ------------------------------------------------------------------
  task automatic write_frame(input logic [7:0] addr8, input logic [7:0] ptr,
                             input logic [15:0] w0, input logic [15:0] w1,
                             input int nwords, output int acks);
    logic [15:0] word;
    acks = 0;
    sda_low_out = 1'b1;
    #(2 * qtr);
    scl_out = 1'b0;
    put_byte({addr8[7:1], 1'b0}, acks);
    put_byte(ptr, acks);
    for (int i = 0; i < nwords; i++) begin
      word = (i == 0) ? w0 : w1;
      put_byte(word[7:0], acks);
      put_byte(word[15:8], acks);
    end
    // No count byte and no check byte: data simply runs to the stop
    stop_bus();
  endtask

  // Stop: data pulled low under a low clock, clock up, then data released
  task automatic stop_bus;
    #qtr;
    sda_low_out = 1'b1;
    #qtr;
    scl_out = 1'b1;
    #(2 * qtr);
    sda_low_out = 1'b0;
    #(2 * qtr);
  endtask

  // Pointer write, repeated start, then one word read back low byte first
  task automatic read_word(input logic [7:0] addr8, input logic [7:0] ptr,
                           output logic [15:0] word, output int acks);
    logic s;
    acks = 0;
    word = 16'h0000;
    sda_low_out = 1'b1;
    #(2 * qtr);
    scl_out = 1'b0;
    put_byte({addr8[7:1], 1'b0}, acks);
    put_byte(ptr, acks);
    // Repeated start: clock up with data released, then data pulled low
    #qtr;
    scl_out = 1'b1;
    #qtr;
    sda_low_out = 1'b1;
    #qtr;
    scl_out = 1'b0;
    put_byte({addr8[7:1], 1'b1}, acks);
    for (int i = 0; i < 16; i++) begin
      put_bit(1'b1, s);
      word[(i < 8) ? (7 - i) : (23 - i)] = s;
      // Acknowledge the low byte, refuse the high one to end the read
      if (i == 7 || i == 15) put_bit(i == 15, s);
    end
    stop_bus();
  endtask
endmodule

// file: verif/charger_limit_regs_tb_top.sv
// Self-checking bench for the charger limit registers over the two-wire link.
`timescale 1ns/100ps
module charger_limit_regs_tb_top import charger_pkg::*;;
  localparam logic [7:0] ADDR8 = {TARGET_ADDR_DEFAULT, 1'b0};
  logic        clk_in = 1'b0;
  logic        link_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        reg_reset_in = 1'b0;
  logic        watchdog_expired_in = 1'b0;
  logic [8:0]  current_set_pin_in = 9'h1FF;
  logic        scl;
  logic        m_low;
  logic        sda_out;
  logic        sda_oe_out;
  logic [8:0]  current_code_out;
  logic [14:0] current_ma_out;
  logic [4:0]  feedback_code_out;
  logic [10:0] feedback_mv_out;
  logic [15:0] voltage_limit_out;
  logic [15:0] current_limit_out;
  logic [8:0]  exp_i;
  logic [4:0]  exp_v;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          acks;
  logic [15:0] cw [5] = '{16'h0000, 16'h001C, 16'h0020, 16'h07FC, 16'hFFFF};
  logic [8:0]  ce [5] = '{9'h008, 9'h008, 9'h008, 9'h190, 9'h190};

  // ------------------------------------------------------------------
  // Clocks, open-drain data line and instances
  // ------------------------------------------------------------------
  always #5 clk_in = ~clk_in;
  // Odd start offset keeps the link clock out of step with clk_in
  initial begin
    #1.7;
    forever #3 link_clk_in = ~link_clk_in;
  end
  wire sda_w = !(m_low || (sda_oe_out && !sda_out));

  charger_limit_regs #(.TARGET_ADDR(TARGET_ADDR_DEFAULT)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .reg_reset_in(reg_reset_in), .watchdog_expired_in(watchdog_expired_in),
    .current_set_pin_in(current_set_pin_in), .current_code_out(current_code_out),
    .current_ma_out(current_ma_out), .feedback_code_out(feedback_code_out),
    .feedback_mv_out(feedback_mv_out), .voltage_limit_out(voltage_limit_out),
    .current_limit_out(current_limit_out));

  charge_bus_master_model u_master (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda_w));

  // ------------------------------------------------------------------
  // Expectation helpers and checks
  // ------------------------------------------------------------------
  // Requests under the bottom of the range fall back to the lowest code
  function automatic logic [4:0] volt_code(input int mv);
    if (mv < 1504) return 5'h00;
    return ((mv - 1504) / 2 > 31) ? 5'h1F : 5'((mv - 1504) / 2);
  endfunction

  function automatic logic [8:0] dev_clamp(input logic [8:0] c);
    return (c < CURR_MIN) ? CURR_MIN : ((c > CURR_MAX) ? CURR_MAX : c);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic check_all;
    logic [8:0] eff;
    eff = (exp_i < current_set_pin_in) ? exp_i : current_set_pin_in;
    check(current_limit_out, {5'h00, exp_i, 2'b00});
    check(voltage_limit_out, {11'h000, exp_v});
    check({11'h000, feedback_code_out}, {11'h000, exp_v});
    check({5'h00, feedback_mv_out}, {5'h00, VFB_OFFSET_MV + VFB_STEP_MV * exp_v});
    check({7'h00, current_code_out}, {7'h00, eff});
    check({1'b0, current_ma_out}, {1'b0, CURR_STEP_MA * eff});
  endtask

  // One write frame, then time for the crossing before the compare
  task automatic wr(input logic [7:0] a8, input logic [7:0] ptr, input logic [15:0] w0,
                    input logic [15:0] w1, input int n, input int exp_acks);
    u_master.write_frame(a8, ptr, w0, w1, n, acks);
    check(16'(acks), 16'(exp_acks));
    repeat (20) @(negedge clk_in);
    check_all();
  endtask

  // Word read back over the link; three bytes are acknowledged by the target
  task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
    logic [15:0] got;
    u_master.read_word(ADDR8, ptr, got, acks);
    check(16'(acks), 16'h0003);
    check(got, exp);
  endtask

  task automatic pulse(input bit wd);
    @(negedge clk_in);
    if (wd) watchdog_expired_in = 1'b1;
    else reg_reset_in = 1'b1;
    @(negedge clk_in);
    watchdog_expired_in = 1'b0;
    reg_reset_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check_all();
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int mv;
    logic [8:0] raw;
    void'($urandom(66682));
    repeat (8) @(negedge clk_in);
    check(current_limit_out, 16'h0640);
    check(voltage_limit_out, 16'h0010);
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    exp_i = CURR_RESET;
    exp_v = VFB_RESET;
    repeat (150) @(negedge clk_in);
    check_all();
    // Full-rate write of a converted current, then a faster bus
    exp_i = 9'h0AC;
    wr(ADDR8, CURR_REG_ADDR, 16'h02B0, 16'h0000, 1, 4);
    u_master.qtr = 125;
    exp_v = 5'h1F;
    exp_i = 9'h064;
    wr(ADDR8, VOLT_REG_ADDR, 16'h001F, 16'h0190, 2, 6);
    rd(VOLT_REG_ADDR, {11'h000, exp_v});
    rd(CURR_REG_ADDR, {5'h00, exp_i, 2'b00});
    foreach (cw[k]) begin
      exp_i = ce[k];
      wr(ADDR8, CURR_REG_ADDR, cw[k], 16'h0000, 1, 4);
    end
    // Unmapped pointer is dropped; a foreign address is not answered
    wr(ADDR8, 8'h04, 16'h1234, 16'h0000, 1, 4);
    wr(8'h6C, CURR_REG_ADDR, 16'h0040, 16'h0000, 1, 0);
    @(negedge clk_in);
    current_set_pin_in = 9'h050;
    repeat (3) @(negedge clk_in);
    check_all();
    exp_i = CURR_RESET;
    pulse(1'b1);
    exp_i = 9'h020;
    wr(ADDR8, CURR_REG_ADDR, 16'h0080, 16'h0000, 1, 4);
    exp_i = CURR_RESET;
    exp_v = VFB_RESET;
    pulse(1'b0);
    // Polling loop as the bridge runs it: voltage first, then current
    repeat (6) begin
      @(negedge clk_in);
      current_set_pin_in = 9'($urandom);
      mv = 1400 + int'($urandom % 200);
      raw = 9'(($urandom % 25001) / 50);
      exp_v = volt_code(mv);
      wr(ADDR8, VOLT_REG_ADDR, {11'h000, exp_v}, 16'h0000, 1, 4);
      exp_i = dev_clamp(raw);
      wr(ADDR8, CURR_REG_ADDR, {5'h00, raw, 2'b00}, 16'h0000, 1, 4);
    end
    stop_test();
  end

  // Hang guard: a run this long means the link stopped answering
  initial begin
    #950_000;
    bad_count++;
    stop_test();
  end
endmodule
